// ===== scd_device.sv
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module scd_device #(
	parameter int CSUM_W = 14
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	scd_link_if.device       link,
	input  wire logic [3:0]  own_addr_i,
	input  wire logic [3:0]  stack_pos_i,
	input  wire logic [3:0]  stack_count_i,
	input  wire logic        is_bottom_i,
	input  wire logic        job_done_i,
	input  wire logic        daisy_activity_i,
	input  wire logic [13:0] cfg_word_i,
	input  wire logic [13:0] nv_word_i,
	input  wire logic [13:0] nv_factory_i,
	output logic      [2:0]  job_o,
	output logic      [5:0]  cfg_idx_o,
	output logic             nv_reload_o,
	output logic             scan_continuous_o,
	output logic             balance_enable_flag_o,
	output logic             checksum_fault_flag_o,
	output logic             sleeping_o,
	output logic             wake_clock_o,
	output logic      [3:0]  stack_addr_o,
	output logic      [3:0]  stack_total_o
);
	if (CSUM_W != 14) begin : g_csum_w_check
		$error("scd_device supports a 14-bit checksum only");
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		scd_pkg::scd_state_t st;
		scd_pkg::scd_job_t   job;
		logic [1:0]          seq;
		logic                all;
		logic                check;
		logic                reload;
		logic [5:0]          idx;
		logic [13:0]         acc;
		logic [13:0]         cfg_sum;
		logic [13:0]         shadow_sum;
		logic                scan;
		logic                balance_enable_flag;
		logic                fault;
		logic [3:0]          saddr;
		logic [3:0]          stotal;
		logic                wclk;
		logic                rv;
		logic [1:0]          rsp;
		logic [13:0]         rdata;
		logic                act1;
		logic                act2;
		logic                jd1;
		logic                jd2;
		logic                doze;
	} scd_dev_state_t;

	scd_dev_state_t s_q;
	scd_dev_state_t s_d;

	function automatic logic [13:0] scd_nv_factory_checksum(input logic [13:0] acc, input logic [13:0] w);
		scd_nv_factory_checksum = {acc[12:0], acc[13] ^ acc[4] ^ acc[2] ^ acc[0]} ^ w;
	endfunction : scd_nv_factory_checksum

	logic is_cmd;
	logic for_me;
	assign is_cmd = (link.page == `SCD_PAGE_CMD);
	assign for_me = (link.dev_addr == own_addr_i) || (link.dev_addr == `SCD_ADDR_ALL);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d      = s_q;
		s_d.rv   = 1'b0;
		s_d.act1 = daisy_activity_i;
		s_d.act2 = s_q.act1;
		s_d.jd1  = job_done_i;
		s_d.jd2  = s_q.jd1;
		s_d.wclk = 1'b0;
		case (s_q.st)
			scd_pkg::SCD_ST_IDLE: begin
				if (s_q.reload) begin
					// Shadow registers are reloading; rebuild the shadow checksum.
					s_d.st    = scd_pkg::SCD_ST_CSUM;
					s_d.check = 1'b0;
					s_d.idx   = 6'h00;
					s_d.acc   = `SCD_CSUM_SEED;
				end else if (link.req && for_me) begin
					s_d.rsp   = scd_pkg::SCD_RSP_ACK;
					s_d.st    = scd_pkg::SCD_ST_RESP;
					s_d.rdata = 14'h0000;
					if (!link.upstream_ok) begin
						s_d.rsp = scd_pkg::SCD_RSP_FAIL;
					end else if (link.page == `SCD_PAGE_NVF && link.addr == `SCD_REG_NVF && !link.write) begin
						s_d.rdata = nv_factory_i;
					end else if (link.page == `SCD_PAGE_NVS && link.addr == `SCD_REG_NVS && !link.write) begin
						s_d.rdata = s_q.shadow_sum;
					end else if (!is_cmd || link.write) begin
						s_d.rsp = scd_pkg::SCD_RSP_NAK;
					end else begin
						case (link.addr)
							`SCD_CMD_SCAN_VOLT: begin
								s_d.job = scd_pkg::SCD_JOB_VOLT;
								s_d.st  = scd_pkg::SCD_ST_JOB;
							end
							`SCD_CMD_SCAN_TEMP: begin
								s_d.job = scd_pkg::SCD_JOB_TEMP;
								s_d.st  = scd_pkg::SCD_ST_JOB;
							end
							`SCD_CMD_SCAN_MIX: begin
								s_d.job = scd_pkg::SCD_JOB_MIX;
								s_d.st  = scd_pkg::SCD_ST_JOB;
							end
							`SCD_CMD_SCAN_WIRE: begin
								s_d.job = scd_pkg::SCD_JOB_WIRE;
								s_d.st  = scd_pkg::SCD_ST_JOB;
							end
							`SCD_CMD_SCAN_ALL: begin
								s_d.job = scd_pkg::SCD_JOB_VOLT;
								s_d.all = 1'b1;
								s_d.seq = 2'h0;
								s_d.st  = scd_pkg::SCD_ST_JOB;
							end
							`SCD_CMD_SCAN_CONT: s_d.scan = 1'b1;
							`SCD_CMD_SCAN_INH:  s_d.scan = 1'b0;
							`SCD_CMD_MEASURE: begin
								s_d.job = scd_pkg::SCD_JOB_MEAS;
								s_d.st  = scd_pkg::SCD_ST_JOB;
							end
							`SCD_CMD_IDENTIFY: begin
								s_d.saddr  = stack_pos_i;
								s_d.stotal = stack_count_i;
							end
							`SCD_CMD_SLEEP: begin
								s_d.doze = 1'b1;
								s_d.rsp = scd_pkg::SCD_RSP_ACK;
							end
							`SCD_CMD_ACK: s_d.rsp = scd_pkg::SCD_RSP_ACK;
							`SCD_CMD_WAKEUP: begin
								if (is_bottom_i && link.via_spi) begin
									s_d.st = scd_pkg::SCD_ST_WAKE;
								end else begin
									s_d.rsp = scd_pkg::SCD_RSP_NAK;
								end
							end
							`SCD_CMD_BAL_EN:  s_d.balance_enable_flag = 1'b1;
							`SCD_CMD_BAL_INH: s_d.balance_enable_flag = 1'b0;
							`SCD_CMD_RESET: begin
								s_d.scan   = 1'b0;
								s_d.balance_enable_flag    = 1'b0;
								s_d.fault  = 1'b0;
								s_d.reload = 1'b1;
							end
							`SCD_CMD_CSUM_CALC, `SCD_CMD_CSUM_CHECK: begin
								s_d.st    = scd_pkg::SCD_ST_CSUM;
								s_d.check = (link.addr == `SCD_CMD_CSUM_CHECK);
								s_d.idx   = 6'h00;
								s_d.acc   = `SCD_CSUM_SEED;
							end
							default: s_d.rsp = scd_pkg::SCD_RSP_NAK;
						endcase
					end
				end
			end
			scd_pkg::SCD_ST_JOB: s_d.st = scd_pkg::SCD_ST_WAIT;
			scd_pkg::SCD_ST_WAIT: begin
				if (s_q.jd2) begin
					if (s_q.all && s_q.seq != 2'h2) begin
						s_d.seq = s_q.seq + 2'h1;
						s_d.job = (s_q.seq == 2'h0) ? scd_pkg::SCD_JOB_TEMP : scd_pkg::SCD_JOB_WIRE;
						s_d.st  = scd_pkg::SCD_ST_JOB;
					end else begin
						s_d.all = 1'b0;
						s_d.job = scd_pkg::SCD_JOB_NONE;
						s_d.rsp = scd_pkg::SCD_RSP_DONE;
						s_d.st  = scd_pkg::SCD_ST_RESP;
					end
				end
			end
			scd_pkg::SCD_ST_CSUM: begin
				s_d.acc = scd_nv_factory_checksum(s_q.acc, s_q.reload ? nv_word_i : cfg_word_i);
				s_d.idx = s_q.idx + 6'h01;
				if (s_q.idx == `SCD_CSUM_STEPS) begin
					if (s_q.reload) begin
						s_d.shadow_sum = s_d.acc;
						s_d.reload     = 1'b0;
						s_d.st         = scd_pkg::SCD_ST_IDLE;
					end else begin
						if (s_q.check && s_d.acc != s_q.cfg_sum) begin
							s_d.fault = 1'b1;
						end
						if (!s_q.check) begin
							s_d.cfg_sum = s_d.acc;
						end
						s_d.rsp = scd_pkg::SCD_RSP_ACK;
						s_d.st  = scd_pkg::SCD_ST_RESP;
					end
				end
			end
			scd_pkg::SCD_ST_SLEEP: begin
				if (s_q.act2) begin
					s_d.st = scd_pkg::SCD_ST_IDLE;
				end
			end
			scd_pkg::SCD_ST_WAKE: begin
				// Slow clock runs up the chain until the top answers through the link.
				s_d.wclk = ~s_q.idx[5];
				s_d.idx  = s_q.idx + 6'h01;
				if (s_q.act2) begin
					s_d.rsp = scd_pkg::SCD_RSP_ACK;
					s_d.st  = scd_pkg::SCD_ST_RESP;
				end
			end
			scd_pkg::SCD_ST_RESP: begin
				// Sleep starts in the same cycle its answer is strobed, so the host is never left waiting.
				s_d.rv   = 1'b1;
				s_d.st   = s_q.doze ? scd_pkg::SCD_ST_SLEEP : scd_pkg::SCD_ST_IDLE;
				s_d.doze = 1'b0;
			end
			default: s_d.st = scd_pkg::SCD_ST_IDLE;
		endcase
		// The last answer stands until the next one is about to be strobed.
		if (s_d.st != scd_pkg::SCD_ST_RESP) begin
			s_d.rsp   = s_q.rsp;
			s_d.rdata = s_q.rdata;
		end else if (s_q.st != scd_pkg::SCD_ST_IDLE) begin
			s_d.rdata = 14'h0000;
		end
	end

	// Reset leaves a shadow reload pending so the power-up checksum is built too.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q        <= '0;
			s_q.reload <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign link.resp_valid = s_q.rv;
	assign link.resp       = s_q.rsp;
	assign link.rdata      = s_q.rdata;
	assign link.busy       = (s_q.st != scd_pkg::SCD_ST_IDLE) || s_q.reload;
	assign job_o                 = (s_q.st == scd_pkg::SCD_ST_JOB || s_q.st == scd_pkg::SCD_ST_WAIT) ? s_q.job : 3'h0;
	assign cfg_idx_o             = s_q.idx;
	assign nv_reload_o           = s_q.reload;
	assign scan_continuous_o     = s_q.scan;
	assign balance_enable_flag_o = s_q.balance_enable_flag;
	assign checksum_fault_flag_o = s_q.fault;
	assign sleeping_o            = (s_q.st == scd_pkg::SCD_ST_SLEEP);
	assign wake_clock_o          = s_q.wclk;
	assign stack_addr_o          = s_q.saddr;
	assign stack_total_o         = s_q.stotal;
endmodule : scd_device
`default_nettype wire

// ===== scd_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module scd_host (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	scd_link_if.host         link,
	input  wire logic        haddr_sel_i,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Command word: [31] go, [30] write, [29] spi, [28] upstream ok,
	// [15:12] device address, [10:8] page, [5:0] register address.
	typedef struct packed {
		logic        dwr;
		logic [31:0] daddr;
		logic [31:0] cmd;
		logic        pend;
		logic        busy;
		logic        nak_seen;
		logic [1:0]  rsp;
		logic [13:0] rdata;
		logic [7:0]  retries;
	} scd_host_state_t;

	scd_host_state_t s_q;
	scd_host_state_t s_d;
	logic            take;
	logic            unused_ok;

	assign take      = hsel_i && hready_i && htrans_i[1];
	assign unused_ok = haddr_sel_i ^ (|hsize_i);

	always_comb begin
		s_d = s_q;
		if (take) begin
			s_d.dwr   = hwrite_i;
			s_d.daddr = haddr_i;
		end else if (hready_i) begin
			s_d.dwr = 1'b0;
		end
		if (s_q.dwr && s_q.daddr == `SCD_HREG_CMD && hwdata_i[`SCD_CMD_GO_BIT] && !s_q.busy) begin
			s_d.cmd  = hwdata_i;
			s_d.pend = 1'b1;
		end
		if (s_q.pend && !link.busy) begin
			s_d.pend = 1'b0;
			s_d.busy = 1'b1;
		end
		if (link.resp_valid && s_q.busy) begin
			s_d.rsp   = link.resp;
			s_d.rdata = link.rdata;
			if (link.resp == scd_pkg::SCD_RSP_NAK && !s_q.cmd[30]) begin
				// A refused read is retried once; a refused write never will pass.
				s_d.pend     = !s_q.nak_seen;
				s_d.nak_seen = !s_q.nak_seen;
				s_d.retries  = s_q.retries + 8'h01;
				s_d.busy     = s_q.nak_seen ? 1'b0 : 1'b1;
			end else begin
				s_d.busy     = 1'b0;
				s_d.nak_seen = 1'b0;
			end
		end
		if (s_q.pend && s_q.nak_seen) begin
			s_d.busy = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Commands go out as software wrote them; write, page and register address all come from the command word.
	assign link.req         = s_q.pend && !link.busy;
	assign link.write       = s_q.cmd[30];
	assign link.via_spi     = s_q.cmd[29];
	assign link.upstream_ok = s_q.cmd[28];
	assign link.dev_addr    = s_q.cmd[15:12];
	assign link.page        = s_q.cmd[10:8];
	assign link.addr        = s_q.cmd[5:0];

	always_comb begin
		case (s_q.daddr)
			`SCD_HREG_CMD:    hrdata_o = s_q.cmd;
			`SCD_HREG_STATUS: hrdata_o = {s_q.retries, 20'h00000, unused_ok & 1'b0, s_q.pend, s_q.busy, s_q.nak_seen};
			`SCD_HREG_RESP:   hrdata_o = {16'h0000, s_q.rsp, s_q.rdata};
			default:          hrdata_o = 32'h0000_0000;
		endcase
	end
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
endmodule : scd_host
`default_nettype wire

// ===== scd_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scd_link_if;
	logic        req;
	logic        write;
	logic [2:0]  page;
	logic [5:0]  addr;
	logic [3:0]  dev_addr;
	logic        via_spi;
	logic        upstream_ok;
	logic        resp_valid;
	logic [1:0]  resp;
	logic [13:0] rdata;
	logic        busy;
	modport device (input req, write, page, addr, dev_addr, via_spi, upstream_ok,
		output resp_valid, resp, rdata, busy);
	modport host (output req, write, page, addr, dev_addr, via_spi, upstream_ok,
		input resp_valid, resp, rdata, busy);
endinterface : scd_link_if
`default_nettype wire

// ===== scd_map.svh
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH
`define SCD_PAGE_CMD        3'h3
`define SCD_PAGE_CFG        3'h2
`define SCD_PAGE_NVF        3'h4
`define SCD_PAGE_NVS        3'h5
`define SCD_REG_NVF         6'h3F
`define SCD_REG_NVS         6'h00
`define SCD_CMD_SCAN_VOLT   6'h01
`define SCD_CMD_SCAN_TEMP   6'h02
`define SCD_CMD_SCAN_MIX    6'h03
`define SCD_CMD_SCAN_WIRE   6'h04
`define SCD_CMD_SCAN_ALL    6'h05
`define SCD_CMD_SCAN_CONT   6'h06
`define SCD_CMD_SCAN_INH    6'h07
`define SCD_CMD_MEASURE     6'h08
`define SCD_CMD_IDENTIFY    6'h09
`define SCD_CMD_SLEEP       6'h0A
`define SCD_CMD_NAK         6'h0B
`define SCD_CMD_ACK         6'h0C
`define SCD_CMD_COMM_FAIL   6'h0E
`define SCD_CMD_WAKEUP      6'h0F
`define SCD_CMD_BAL_EN      6'h10
`define SCD_CMD_BAL_INH     6'h11
`define SCD_CMD_RESET       6'h12
`define SCD_CMD_CSUM_CALC   6'h13
`define SCD_CMD_CSUM_CHECK  6'h14
`define SCD_ADDR_ALL        4'hF
`define SCD_NV_CSUM_RST     14'h0000
`define SCD_CSUM_SEED       14'h0001
`define SCD_CSUM_STEPS      6'h3F
`define SCD_HREG_CMD        32'h0000_0000
`define SCD_HREG_STATUS     32'h0000_0004
`define SCD_HREG_RESP       32'h0000_0008
`define SCD_CMD_GO_BIT      31
`endif

// ===== scd_pkg.sv
`default_nettype none
package scd_pkg;
	typedef enum logic [1:0] {
		SCD_RSP_ACK  = 2'h0,
		SCD_RSP_DONE = 2'h1,
		SCD_RSP_NAK  = 2'h3,
		SCD_RSP_FAIL = 2'h2
	} scd_rsp_t;
	// Measurement jobs handed to the front end, one per scan step.
	typedef enum logic [2:0] {
		SCD_JOB_NONE = 3'h0,
		SCD_JOB_VOLT = 3'h1,
		SCD_JOB_TEMP = 3'h3,
		SCD_JOB_MIX  = 3'h2,
		SCD_JOB_WIRE = 3'h6,
		SCD_JOB_MEAS = 3'h7
	} scd_job_t;
	typedef enum logic [2:0] {
		SCD_ST_IDLE  = 3'h0,
		SCD_ST_JOB   = 3'h1,
		SCD_ST_WAIT  = 3'h3,
		SCD_ST_CSUM  = 3'h2,
		SCD_ST_SLEEP = 3'h6,
		SCD_ST_WAKE  = 3'h7,
		SCD_ST_RESP  = 3'h5
	} scd_state_t;
endpackage : scd_pkg
`default_nettype wire

// ===== scd_properties.sv
`timescale 1ns/1ps
`default_nettype none
module scd_properties (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        req,
	input  wire logic        write,
	input  wire logic [2:0]  page,
	input  wire logic [5:0]  addr,
	input  wire logic [3:0]  dev_addr,
	input  wire logic        via_spi,
	input  wire logic        upstream_ok,
	input  wire logic        resp_valid,
	input  wire logic [1:0]  resp,
	input  wire logic [13:0] rdata,
	input  wire logic        busy
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------------------------------
	// Command acceptance
	// ----------------------------------------------------------------
	// Only broadcast requests are judged, since the own address is not seen here.
	logic take;
	logic rd3;
	assign take = req && !busy && dev_addr == 4'hF && upstream_ok;
	assign rd3  = take && !write && page == 3'h3;

	AST_WRITE_NAK: assert property (take && write |-> ##2 resp_valid && resp == 2'h3)
		else $error("write to command page not refused");
	AST_UNASSIGNED_NAK: assert property (rd3 && (addr == 6'h00 || addr == 6'h0D || addr > 6'h14)
		|-> ##2 resp_valid && resp == 2'h3) else $error("unassigned command not refused");
	AST_ACK_REPLY: assert property (rd3 && addr == 6'h0C |-> ##2 resp_valid && resp == 2'h0)
		else $error("acknowledge command not answered");
	AST_UPSTREAM_FAIL: assert property (req && !busy && dev_addr == 4'hF && !upstream_ok && !write
		&& page == 3'h3 && addr == 6'h0C |-> ##2 resp_valid && resp == 2'h2) else $error("no failure reply");
	AST_WAKE_SPI_ONLY: assert property (rd3 && addr == 6'h0F && !via_spi |-> ##2 resp_valid && resp == 2'h3)
		else $error("wakeup accepted off the serial port");
	AST_RESP_PULSE: assert property (resp_valid |=> !resp_valid)
		else $error("response strobe longer than one cycle");
	AST_BUSY_AFTER_TAKE: assert property (take |=> busy)
		else $error("device idle after taking a command");
	AST_RESP_STANDS: assert property ($changed(resp) |-> ##[0:1] resp_valid)
		else $error("response changed without a strobe");
endmodule : scd_properties
`default_nettype wire

// ===== stack_command_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "scd_map.svh"
module stack_command_decoder_test;
	logic        clk_i, rst_n_i, hsel, hwrite, hready, hresp, job_done, daisy, flip, bottom;
	logic        scan_f, bal_f, fault_f, sleeping, wclk, nv_rl;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  job, job_prev;
	logic [3:0]  jc, own_a, pos_a, cnt_a, st_addr, st_total;
	logic [5:0]  idx;
	logic [2:0]  log_q[$];
	int          err_count, num_checks, rl_n, wc_n;

	scd_link_if lnk ();
	scd_host i_scd_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lnk), .haddr_sel_i(1'b0), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
	scd_device i_scd_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .link(lnk), .own_addr_i(own_a),
		.stack_pos_i(pos_a), .stack_count_i(cnt_a), .is_bottom_i(bottom), .job_done_i(job_done),
		.daisy_activity_i(daisy), .cfg_word_i({8'h00, idx} ^ {13'h0000, flip}), .nv_word_i({8'hA5, idx}),
		.nv_factory_i(14'h2A5C), .job_o(job), .cfg_idx_o(idx), .nv_reload_o(nv_rl), .scan_continuous_o(scan_f),
		.balance_enable_flag_o(bal_f), .checksum_fault_flag_o(fault_f), .sleeping_o(sleeping),
		.wake_clock_o(wclk), .stack_addr_o(st_addr), .stack_total_o(st_total));
	scd_properties i_scd_properties (.clk_i(clk_i), .rst_n_i(rst_n_i), .req(lnk.req), .write(lnk.write),
		.page(lnk.page), .addr(lnk.addr), .dev_addr(lnk.dev_addr), .via_spi(lnk.via_spi),
		.upstream_ok(lnk.upstream_ok), .resp_valid(lnk.resp_valid), .resp(lnk.resp), .rdata(lnk.rdata),
		.busy(lnk.busy));

	// ----------------------------------------------------------------
	// Front end stand-in
	// ----------------------------------------------------------------
	// Every job finishes a few cycles after it starts, so a stuck job shows up as a timeout.
	always @(posedge clk_i) begin
		job_prev <= job;
		jc       <= (job != job_prev) ? 4'h0 : jc + 4'h1;
		job_done <= job != 3'h0 && jc == 4'h4;
		if (job != job_prev && job != 3'h0)
			log_q.push_back(job);
		if (nv_rl === 1'b1)
			rl_n++;
	end
	always @(wclk) wc_n++;

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	task automatic report_and_stop;
		if (err_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	task automatic tmo;
		err_count++;
		$display("ERROR %0t wait timed out", $time);
		report_and_stop();
	endtask : tmo

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic hwait;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (n == 50)
			tmo();
	endtask : hwait

	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge clk_i);
		hsel   <= 1'b1;
		haddr  <= a;
		hwrite <= w;
		htrans <= 2'h2;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		r = hrdata;
	endtask : ahb

	task automatic await(input logic [1:0] e);
		int n;
		for (n = 0; lnk.resp_valid !== 1'b1; n++) begin
			if (n == 800)
				tmo();
			@(negedge clk_i);
		end
		if (e !== 2'bxx)
			chk(lnk.resp, e);
		@(negedge clk_i);
	endtask : await

	task automatic idle;
		int n;
		for (n = 0; lnk.busy !== 1'b0; n++) begin
			if (n == 300)
				tmo();
			@(negedge clk_i);
		end
	endtask : idle

	// An answer of all x means the code is not judged, only that one arrives.
	task automatic cmd(input logic w, s, u, input logic [3:0] d, input logic [5:0] a, input logic [1:0] e);
		logic [31:0] r;
		ahb(1'b1, 32'h0, {1'b1, w, s, u, 12'h000, d, 1'b0, 3'h3, 2'h0, a}, r);
		await(e);
		if (e === 2'h3 && !w)
			await(e);
		ahb(1'b0, 32'h8, 32'h0, r);
		if (e !== 2'bxx)
			chk(r[15:14], e);
		repeat (2) @(posedge clk_i);
	endtask : cmd

	task automatic rc(input logic [5:0] a, input logic [1:0] e);
		cmd(1'b0, 1'b1, 1'b1, 4'hF, a, e);
	endtask : rc

	task automatic t_nv;
		logic [31:0] r;
		ahb(1'b1, `SCD_HREG_CMD, 32'hB000_F43F, r);
		await(2'h0);
		ahb(1'b0, `SCD_HREG_RESP, 32'h0, r);
		chk(r[13:0], 14'h2A5C);
		ahb(1'b1, `SCD_HREG_CMD, 32'hB000_F500, r);
		await(2'h0);
		ahb(1'b0, `SCD_HREG_RESP, 32'h0, r);
		chk(r[13:0] != 14'h0000, 1'b1);
	endtask : t_nv

	task automatic t_flags;
		logic [31:0] r;
		rc(6'h06, 2'bxx);
		chk(scan_f, 1'b1);
		rc(6'h07, 2'bxx);
		chk(scan_f, 1'b0);
		rc(6'h10, 2'bxx);
		chk(bal_f, 1'b1);
		rc(6'h0C, 2'h0);
		chk(bal_f, 1'b1);
		cmd(1'b0, 1'b1, 1'b1, 4'h3, 6'h11, 2'bxx);
		chk(bal_f, 1'b0);
		ahb(1'b0, 32'h10, 32'h0, r);
		chk(hresp, 1'b0);
	endtask : t_flags

	task automatic t_scans;
		logic [5:0] ca[5] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h08};
		logic [2:0] ja[5] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h7};
		for (int i = 0; i < 5; i++) begin
			log_q.delete();
			rc(ca[i], 2'h1);
			chk(log_q.size(), 1);
			chk(log_q[0], ja[i]);
		end
		log_q.delete();
		rc(6'h05, 2'h1);
		chk(log_q.size(), 3);
		chk({log_q[0], log_q[1], log_q[2]}, 9'h05E);
	endtask : t_scans

	task automatic t_refuse;
		cmd(1'b1, 1'b1, 1'b1, 4'hF, 6'h0C, 2'h3);
		rc(6'h00, 2'h3);
		rc(6'h0D, 2'h3);
		rc(6'h15, 2'h3);
		cmd(1'b0, 1'b0, 1'b1, 4'hF, 6'h0F, 2'h3);
		cmd(1'b0, 1'b1, 1'b0, 4'hF, 6'h0C, 2'h2);
		bottom <= 1'b0;
		rc(6'h0F, 2'h3);
		bottom <= 1'b1;
	endtask : t_refuse

	task automatic t_ident;
		rc(6'h09, 2'bxx);
		chk(st_addr, 4'h5);
		chk(st_total, 4'h9);
	endtask : t_ident

	task automatic t_csum;
		int r0;
		rc(6'h10, 2'bxx);
		rc(6'h13, 2'bxx);
		rc(6'h14, 2'bxx);
		chk(fault_f, 1'b0);
		flip <= 1'b1;
		rc(6'h14, 2'bxx);
		chk(fault_f, 1'b1);
		flip <= 1'b0;
		r0 = rl_n;
		rc(6'h12, 2'bxx);
		idle();
		chk({scan_f, bal_f, fault_f}, 3'h0);
		chk(rl_n != r0, 1'b1);
		rc(6'h09, 2'bxx);
		chk(st_addr, 4'h5);
	endtask : t_csum

	task automatic t_sleep;
		int n;
		rc(6'h0A, 2'h0);
		repeat (10) @(posedge clk_i);
		chk(sleeping, 1'b1);
		daisy <= 1'b1;
		@(posedge clk_i);
		daisy <= 1'b0;
		for (n = 0; sleeping !== 1'b0; n++) begin
			if (n == 50)
				tmo();
			@(negedge clk_i);
		end
		n = wc_n;
		// The top of the stack answers over the daisy link once the slow clock has reached it.
		fork
			rc(6'h0F, 2'h0);
			begin
				for (int k = 0; wc_n == n && k < 200; k++)
					@(posedge clk_i);
				repeat (4) @(posedge clk_i);
				daisy <= 1'b1;
				@(posedge clk_i);
				daisy <= 1'b0;
			end
		join
		chk(wc_n != n, 1'b1);
	endtask : t_sleep

	initial begin
		rst_n_i    = 1'b0;
		{hsel, hwrite, job_done, daisy, flip} = 5'h00;
		haddr      = 32'h0;
		hwdata     = 32'h0;
		htrans     = 2'h0;
		job_prev   = 3'h0;
		jc         = 4'h0;
		own_a      = 4'h3;
		pos_a      = 4'h5;
		cnt_a      = 4'h9;
		bottom     = 1'b1;
		err_count  = 0;
		num_checks = 0;
		rl_n       = 0;
		wc_n       = 0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		idle();
		chk(rl_n != 0, 1'b1);
		t_nv();
		t_flags();
		t_scans();
		t_refuse();
		t_ident();
		t_csum();
		t_sleep();
		report_and_stop();
	end
endmodule : stack_command_decoder_test
`default_nettype wire
